// [core/dps_pkg.sv]
// Constants and decode helpers for the dual potentiometer serial block.
// Assumes one 100 MHz clock shared by both ends of the link.
package dps_pkg;

  // ************************************************************
  // Serial instruction format
  // ************************************************************
  localparam logic [2:0] OP_NOP = 3'h0;
  localparam logic [2:0] OP_ACR_RD = 3'h1;
  localparam logic [2:0] OP_ACR_WR = 3'h3;
  localparam logic [2:0] OP_REG_RD = 3'h4;
  localparam logic [2:0] OP_REG_WR = 3'h6;
  localparam logic [2:0] RD_TAG = 3'h7;
  localparam int OP_MSB = 15;
  localparam int OP_LSB = 13;
  localparam int ADDR_MSB = 12;
  localparam int ADDR_LSB = 8;

  // ************************************************************
  // Device register map
  // ************************************************************
  localparam logic [4:0] ADDR_WIPER0 = 5'h00;
  localparam logic [4:0] ADDR_WIPER1 = 5'h01;
  localparam logic [4:0] ADDR_ACR = 5'h10;
  localparam logic [7:0] WIPER_RST = 8'h40;
  localparam logic [7:0] ACR_RST = 8'h40;
  localparam logic [7:0] ACR_MASK = 8'h42;
  localparam int ACR_SHUTDOWN_N_BIT_N_BIT = 6;
  localparam int ACR_SDO_OD_BIT = 1;
  localparam logic [3:0] LAST_BIT = 4'hf;

  // ************************************************************
  // Host timing and its register map
  // ************************************************************
  localparam int CLK_NS = 10;
  localparam int SCK_HALF_NS = 100;
  localparam int CS_GAP_NS = 2000;
  localparam logic [7:0] SCK_HALF_CYC = 8'((SCK_HALF_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [7:0] CS_GAP_CYC = 8'((CS_GAP_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [7:0] HOST_TX_OFS = 8'h00;
  localparam logic [7:0] HOST_CTRL_OFS = 8'h04;
  localparam logic [7:0] HOST_STAT_OFS = 8'h08;
  localparam logic [7:0] HOST_RX_OFS = 8'h0c;
  localparam int CTRL_GO_BIT = 8;

  typedef enum logic [2:0] {H_IDLE, H_SETUP, H_HIGH, H_LAG, H_GAP} dps_host_e;

  // Opcode 001/011 always target the control register
  function automatic logic [4:0] dps_target(input logic [2:0] op, input logic [4:0] addr);
    dps_target = (op == OP_ACR_RD || op == OP_ACR_WR) ? ADDR_ACR : addr;
  endfunction

endpackage

// [core/dps_spi_if.sv]
// Serial link between the host controller and the potentiometer device.
// Assumes an external pull-up on the device output line.
`timescale 1ns/1ns
interface dps_spi_if;
  logic sck;
  logic cs_n;
  logic sdi;
  logic sdo_o;
  logic sdo_oe;
  logic sdo;

  // Released line floats high through the pull-up
  assign sdo = sdo_oe ? sdo_o : 1'b1;

  modport dev (
    input sck,
    input cs_n,
    input sdi,
    output sdo_o,
    output sdo_oe
  );

  modport host (
    output sck,
    output cs_n,
    output sdi,
    input sdo
  );
endinterface

// [core/dps_device.sv]
// Potentiometer device end: serial slave plus wiper and control registers.
// Assumes link pins are synchronous to pclk and slow against it.
//
// Register access over the serial link was chosen for this implementation.
`timescale 1ns/1ns
module dps_device
  import dps_pkg::*;
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Serial link
  dps_spi_if.dev link,
  // Potentiometer controls
  output logic [7:0] wiper_position_0,
  output logic [7:0] wiper_position_1,
  output logic shutdown_n_bit,
  output logic sdo_open_drain,
  output logic active_mode
);

  // ************************************************************
  // State
  // ************************************************************
  logic sck_q;
  logic cs_n_q;
  logic selected_q;
  logic [15:0] sr_q;
  logic [3:0] cnt_q;
  logic full_q;
  logic first_q;
  logic [7:0] wiper0_q;
  logic [7:0] wiper1_q;
  logic [7:0] acr_q;
  logic sdo_q;
  logic sdo_oe_q;

  logic cs_fall;
  logic cs_rise;
  logic sck_rise;
  logic sck_fall;
  logic [15:0] word_in;
  logic [2:0] in_op;
  logic [4:0] in_tgt;
  logic [2:0] sr_op;
  logic [4:0] sr_tgt;
  logic [7:0] sr_data;
  logic word_ok;
  logic od;
  logic wr_ok;

  function automatic logic mapped(input logic [4:0] a);
    mapped = (a == ADDR_WIPER0) || (a == ADDR_WIPER1) || (a == ADDR_ACR);
  endfunction

  function automatic logic [7:0] reg_value(input logic [4:0] a, input logic [7:0] w0,
                                           input logic [7:0] w1, input logic [7:0] access_control);
    unique case (a)
      ADDR_WIPER0: reg_value = w0;
      ADDR_WIPER1: reg_value = w1;
      ADDR_ACR: reg_value = access_control;
      default: reg_value = 8'h00;
    endcase
  endfunction

  // ************************************************************
  // Edge detection on the link pins
  // ************************************************************
  // Pins are already in the pclk domain, so one stage finds the edges
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sck_q <= 1'b0;
      cs_n_q <= 1'b0;
    end else begin
      sck_q <= link.sck;
      cs_n_q <= link.cs_n;
    end
  end

  // Reset value of low means select held low at start gives no fall
  assign cs_fall = cs_n_q & ~link.cs_n;
  assign cs_rise = ~cs_n_q & link.cs_n & selected_q;
  assign sck_rise = selected_q & ~link.cs_n & link.sck & ~sck_q;
  assign sck_fall = selected_q & ~link.cs_n & ~link.sck & sck_q;

  // Select held low through reset is ignored until it rises
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      selected_q <= 1'b0;
    end else if (cs_fall) begin
      selected_q <= 1'b1;
    end else if (link.cs_n) begin
      selected_q <= 1'b0;
    end
  end

  // ************************************************************
  // Shift register and framing
  // ************************************************************
  // Limitation: chained reads within a frame are not supported
  assign word_in = {sr_q[14:0], link.sdi};
  assign in_op = word_in[OP_MSB:OP_LSB];
  assign in_tgt = dps_target(in_op, word_in[ADDR_MSB:ADDR_LSB]);
  assign sr_op = sr_q[OP_MSB:OP_LSB];
  assign sr_tgt = dps_target(sr_op, sr_q[ADDR_MSB:ADDR_LSB]);
  assign sr_data = sr_q[7:0];
  assign word_ok = full_q && (cnt_q == 4'h0);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q <= 4'h0;
      full_q <= 1'b0;
      first_q <= 1'b0;
    end else if (cs_fall) begin
      cnt_q <= 4'h0;
      full_q <= 1'b0;
      first_q <= 1'b1;
    end else if (sck_rise) begin
      cnt_q <= cnt_q + 4'h1;
      if (cnt_q == LAST_BIT) begin
        full_q <= 1'b1;
        first_q <= 1'b0;
      end
    end
  end

  // First word of a frame that is a read is swapped for its reply
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sr_q <= 16'h0000;
    end else if (sck_rise) begin
      if (first_q && cnt_q == LAST_BIT && (in_op == OP_ACR_RD || in_op == OP_REG_RD)) begin
        sr_q <= {RD_TAG, in_tgt,
                 reg_value(in_tgt, wiper0_q, wiper1_q, acr_q)};
      end else begin
        sr_q <= word_in;
      end
    end
  end

  // ************************************************************
  // Register writes, taken only at select rise
  // ************************************************************
  // Decoding at select rise keeps a cut or padded frame harmless
  assign wr_ok = cs_rise && word_ok && mapped(sr_tgt);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wiper0_q <= WIPER_RST;
      wiper1_q <= WIPER_RST;
    end else if (wr_ok && sr_op == OP_REG_WR) begin
      // Shutdown never touches these, so positions survive it
      if (sr_tgt == ADDR_WIPER0) begin
        wiper0_q <= sr_data;
      end else if (sr_tgt == ADDR_WIPER1) begin
        wiper1_q <= sr_data;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      acr_q <= ACR_RST;
    end else if (wr_ok && (sr_op == OP_ACR_WR || sr_op == OP_REG_WR)
                 && sr_tgt == ADDR_ACR) begin
      acr_q <= sr_data & ACR_MASK;
    end
  end

  // Other opcodes and unmapped targets fall through with no effect

  // ************************************************************
  // Serial output driver
  // ************************************************************
  // Open drain drives only zeros; the pull-up supplies the ones
  assign od = acr_q[ACR_SDO_OD_BIT];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sdo_q <= 1'b1;
      sdo_oe_q <= 1'b0;
    end else if (cs_fall || sck_fall) begin
      // New bit launched at select fall and on each falling clock edge
      sdo_q <= sr_q[15];
      sdo_oe_q <= od ? ~sr_q[15] : 1'b1;
    end else if (link.cs_n) begin
      sdo_q <= 1'b1;
      sdo_oe_q <= 1'b0;
    end
  end

  assign link.sdo_o = sdo_q;
  assign link.sdo_oe = sdo_oe_q;

  // ************************************************************
  // User side outputs
  // ************************************************************
  // Registered, so it trails the select state by one cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      active_mode <= 1'b0;
    end else begin
      active_mode <= selected_q;
    end
  end

  assign wiper_position_0 = wiper0_q;
  assign wiper_position_1 = wiper1_q;
  assign shutdown_n_bit = acr_q[ACR_SHUTDOWN_N_BIT_N_BIT];
  assign sdo_open_drain = acr_q[ACR_SDO_OD_BIT];

endmodule

// [core/dps_host.sv]
// Host end: APB slave registers driving a mode 0 serial master.
// Assumes software waits for busy to clear before a new start.
`timescale 1ns/1ns
module dps_host
  import dps_pkg::*;
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Serial link
  dps_spi_if.host link
);

  // ************************************************************
  // State
  // ************************************************************
  dps_host_e st_q;
  logic [7:0] tmr_q;
  logic [31:0] tx_q;
  logic [31:0] sh_q;
  logic [31:0] rx_q;
  logic [4:0] bits_q;
  logic [1:0] nbm1_q;
  logic sck_q;
  logic cs_n_q;
  logic mosi_q;
  logic pready_q;
  logic pslverr_q;
  logic [31:0] prdata_q;
  logic tick;
  logic wr_en;
  logic go;

  function automatic logic mapped(input logic [7:0] a);
    mapped = (a == HOST_TX_OFS) || (a == HOST_CTRL_OFS) || (a == HOST_STAT_OFS)
             || (a == HOST_RX_OFS);
  endfunction

  // ************************************************************
  // APB slave, answers in the first access cycle
  // ************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h00000000;
    end else begin
      pready_q <= psel & ~penable;
      pslverr_q <= psel & ~penable & ~mapped(paddr);
      unique case (paddr)
        HOST_TX_OFS: prdata_q <= tx_q;
        HOST_CTRL_OFS: prdata_q <= {30'h00000000, nbm1_q};
        HOST_STAT_OFS: prdata_q <= {31'h00000000, st_q != H_IDLE};
        HOST_RX_OFS: prdata_q <= rx_q;
        default: prdata_q <= 32'h00000000;
      endcase
    end
  end

  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign prdata = prdata_q;
  assign wr_en = psel & penable & pwrite & pready_q;
  assign go = wr_en && paddr == HOST_CTRL_OFS && pwdata[CTRL_GO_BIT] && st_q == H_IDLE;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_q <= 32'h00000000;
      nbm1_q <= 2'h0;
    end else if (wr_en && paddr == HOST_TX_OFS) begin
      tx_q <= pwdata;
    end else if (wr_en && paddr == HOST_CTRL_OFS && st_q == H_IDLE) begin
      nbm1_q <= pwdata[1:0];
    end
  end

  // ************************************************************
  // Half period divider
  // ************************************************************
  assign tick = (st_q != H_IDLE) && (tmr_q == 8'h00);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tmr_q <= 8'h00;
    end else if (go || (tick && st_q != H_LAG)) begin
      tmr_q <= SCK_HALF_CYC - 8'h01;
    end else if (tick) begin
      tmr_q <= CS_GAP_CYC - 8'h01;
    end else if (st_q != H_IDLE) begin
      tmr_q <= tmr_q - 8'h01;
    end
  end

  // ************************************************************
  // Frame sequencer, mode 0
  // ************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q <= H_IDLE;
      cs_n_q <= 1'b1;
      sck_q <= 1'b0;
      mosi_q <= 1'b0;
      sh_q <= 32'h00000000;
      rx_q <= 32'h00000000;
      bits_q <= 5'h00;
    end else if (go) begin
      st_q <= H_SETUP;
      cs_n_q <= 1'b0;
      sh_q <= tx_q;
      mosi_q <= tx_q[31];
      rx_q <= 32'h00000000;
      bits_q <= {pwdata[1:0], 3'h7};
    end else if (tick) begin
      unique case (st_q)
        H_SETUP: begin
          sck_q <= 1'b1;
          rx_q <= {rx_q[30:0], link.sdo};
          st_q <= H_HIGH;
        end
        H_HIGH: begin
          sck_q <= 1'b0;
          if (bits_q == 5'h00) begin
            st_q <= H_LAG;
          end else begin
            bits_q <= bits_q - 5'h01;
            sh_q <= {sh_q[30:0], 1'b0};
            mosi_q <= sh_q[30];
            st_q <= H_SETUP;
          end
        end
        H_LAG: begin
          cs_n_q <= 1'b1;
          st_q <= H_GAP;
        end
        H_GAP: st_q <= H_IDLE;
        default: st_q <= H_IDLE;
      endcase
    end
  end

  assign link.sck = sck_q;
  assign link.cs_n = cs_n_q;
  assign link.sdi = mosi_q;

endmodule

// [verification/dps_link_assertions.sv]
// Checker for the serial link between the host and device ends.
// Assumes one pclk domain; instantiated beside the interface, no bind.
`timescale 1ns/1ns
module dps_link_assertions (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Serial link
  input wire logic sck,
  input wire logic cs_n,
  input wire logic sdi,
  input wire logic sdo_o,
  input wire logic sdo_oe
);
  // ************************************************************
  // Helper counters
  // ************************************************************
  logic [7:0] fall_q;
  logic [7:0] gap_q;
  logic [5:0] rise_q;

  // Cycles since the last launching edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      fall_q <= 8'hff;
    else if ($fell(sck) || $fell(cs_n))
      fall_q <= 8'h00;
    else if (fall_q != 8'hff)
      fall_q <= fall_q + 8'h01;
  end

  // Starts saturated so the first frame after reset is not flagged
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      gap_q <= 8'hff;
    else if (!cs_n)
      gap_q <= 8'h00;
    else if (gap_q != 8'hff)
      gap_q <= gap_q + 8'h01;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      rise_q <= 6'h00;
    else if ($fell(cs_n))
      rise_q <= 6'h00;
    else if ($rose(sck))
      rise_q <= rise_q + 6'h01;
  end

  // ************************************************************
  // Properties
  // ************************************************************
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_sck_high;
    sck [*8] ##1 sck ##1 sck ##1 !sck;
  endsequence

  sequence s_lead;
    !sck [*8] ##1 !sck ##1 !sck ##1 sck;
  endsequence

  a_sdo_release: assert property (cs_n [*4] |-> !sdo_oe)
    else $error("output still driven while deselected");
  a_sdo_launch_fall: assert property (!cs_n && $changed(sdo_o) |-> fall_q <= 8'd3)
    else $error("output bit changed away from a falling clock");
  a_sck_idle_low: assert property (cs_n |-> !sck)
    else $error("serial clock high while deselected");
  a_sck_high_time: assert property ($rose(sck) |-> s_sck_high)
    else $error("serial clock high phase not ten cycles");
  a_sdi_on_fall: assert property (!cs_n && !$fell(cs_n) && $changed(sdi) |-> $fell(sck))
    else $error("input bit changed away from a falling clock");
  a_frame_bytes: assert property ($rose(cs_n) |-> rise_q != 6'd0 && rise_q[2:0] == 3'd0)
    else $error("frame is not whole bytes");
  a_select_gap: assert property ($fell(cs_n) |-> !sck && gap_q >= 8'd199)
    else $error("select fell too soon or with clock high");
  a_select_lead: assert property ($fell(cs_n) |-> s_lead)
    else $error("first clock rise not ten cycles after select");
endmodule

// [verification/dual_pot_spi_register_slave_tb.sv]
// Self-checking bench: APB host end and device end joined by the link.
// Assumes 100 MHz pclk and registers on the host reached over APB.
`timescale 1ns/1ns
module dual_pot_spi_register_slave_tb;
  import dps_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, e;
  logic [7:0] paddr, w0, w1, e_w0, e_w1, e_ctl, d;
  logic [31:0] pwdata, prdata, rx, q, tx;
  logic [4:0] a;
  logic shut_n, od, active, act_seen, od_bad;
  int errors, check_count, seed;
  logic [31:0] bad_tx [6] = '{32'h002a0000, 32'h402a0000, 32'ha02a0000, 32'he02a0000,
    32'hc22a0000, 32'hdf2a0000};

  dps_spi_if link ();
  dps_host dps_host_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .link(link));
  dps_device dps_device_i (.pclk(pclk), .presetn(presetn), .link(link), .wiper_position_0(w0),
    .wiper_position_1(w1), .shutdown_n_bit(shut_n), .sdo_open_drain(od), .active_mode(active));
  dps_link_assertions dps_link_assertions_i (.pclk(pclk), .presetn(presetn), .sck(link.sck),
    .cs_n(link.cs_n), .sdi(link.sdi), .sdo_o(link.sdo_o), .sdo_oe(link.sdo_oe));

  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  // Open drain must never drive a one; the pull-up makes it
  always @(posedge pclk) begin
    if (!link.cs_n && active)
      act_seen <= 1'b1;
    if (od && link.sdo_oe && link.sdo_o)
      od_bad <= 1'b1;
  end

  // ************************************************************
  // Compare and bus tasks
  // ************************************************************
  task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_bit(input logic got, input logic exp);
    chk_val({31'h0, got}, {31'h0, exp});
  endtask

  // Only the shutdown and output type bits exist in the control register
  function automatic logic [7:0] exp_ctl(input logic [7:0] v);
    exp_ctl = {1'b0, v[6], 4'h0, v[1], 1'b0};
  endfunction

  // Read reply word: tag 111b, target address, register data
  function automatic logic [31:0] exp_reply(input logic [4:0] t, input logic [7:0] v);
    exp_reply = {16'h0, 3'h7, t, v};
  endfunction

  task automatic chk_regs();
    chk_val({24'h0, w0}, {24'h0, e_w0});
    chk_val({24'h0, w1}, {24'h0, e_w1});
    chk_bit(shut_n, e_ctl[6]);
    chk_bit(od, e_ctl[1]);
  endtask

  task automatic apb(input logic wr, input logic [7:0] ad, input logic [31:0] wd,
    output logic [31:0] rd, output logic err);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= ad;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    // Any wait count is taken; only the watchdog ends a hang
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Polls busy; a stuck frame counts as a mismatch
  task automatic xfer(input logic [31:0] t, input logic [1:0] nb);
    int n;
    n = 0;
    apb(1'b1, 8'h00, t, q, e);
    apb(1'b1, 8'h04, {23'h0, 1'b1, 6'h0, nb}, q, e);
    do begin
      apb(1'b0, 8'h08, 32'h0, q, e);
      n++;
    end while (q[0] !== 1'b0 && n < 2000);
    if (n >= 2000)
      errors++;
    apb(1'b0, 8'h0c, 32'h0, rx, e);
    repeat (3) @(posedge pclk);
  endtask

  task automatic wr(input logic [2:0] op, input logic [4:0] ad, input logic [7:0] v);
    xfer({op, ad, v, 16'h0}, 2'd1);
  endtask

  task automatic rd(input logic [2:0] op, input logic [4:0] ad, input logic [4:0] t,
    input logic [7:0] v);
    xfer({op, ad, 24'h0}, 2'd3);
    chk_val({16'h0, rx[15:0]}, exp_reply(t, v));
  endtask

  task automatic complete_run();
    $display("errors %0d checks %0d", errors, check_count);
    if (errors == 0 && check_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // ************************************************************
  // Scenarios
  // ************************************************************
  initial begin
    repeat (80000) @(posedge pclk);
    errors++;
    complete_run();
  end

  initial begin
    {psel, penable, pwrite, presetn, act_seen, od_bad} = 6'h0;
    paddr = 8'h00;
    pwdata = 32'h0;
    errors = 0;
    check_count = 0;
    seed = 32'h0c0c1cf8;
    {e_w0, e_w1, e_ctl} = {8'h40, 8'h40, 8'h40};
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    chk_regs();
    chk_bit(link.sdo_oe, 1'b0);
    rd(OP_ACR_RD, 5'h0b, 5'h10, 8'h40);
    rd(OP_REG_RD, 5'h10, 5'h10, 8'h40);
    for (int i = 0; i < 8; i++) begin
      a = 5'($random(seed) & 1);
      d = (i == 0) ? 8'h00 : (i == 1) ? 8'h7f : 8'($random(seed) & 8'h7f);
      wr(OP_REG_WR, a, d);
      if (a == 5'h00)
        e_w0 = d;
      else
        e_w1 = d;
      chk_regs();
      rd(OP_REG_RD, a, a, d);
    end
    chk_bit(act_seen, 1'b1);
    chk_bit(active, 1'b0);
    wr(OP_ACR_WR, 5'h05, 8'hff);
    e_ctl = exp_ctl(8'hff);
    chk_regs();
    rd(OP_REG_RD, 5'h10, 5'h10, e_ctl);
    chk_bit(od_bad, 1'b0);
    wr(OP_REG_WR, 5'h10, 8'h00);
    e_ctl = exp_ctl(8'h00);
    chk_regs();
    wr(OP_ACR_WR, 5'h00, 8'h40);
    e_ctl = 8'h40;
    chk_regs();
    for (int k = 0; k < 6; k++) begin
      xfer(bad_tx[k], 2'd1);
      chk_regs();
    end
    xfer(32'hc12a0000, 2'd0);
    chk_regs();
    xfer(32'hc12a0000, 2'd2);
    chk_regs();
    d = 8'($random(seed) & 8'h7f);
    tx = {3'h0, 13'($random(seed)), OP_REG_WR, 5'h01, d};
    xfer(tx, 2'd3);
    e_w1 = d;
    chk_regs();
    chk_val({16'h0, rx[15:0]}, {16'h0, tx[31:16]});
    apb(1'b0, 8'h00, 32'h0, q, e);
    chk_val(q, tx);
    chk_bit(e, 1'b0);
    apb(1'b0, 8'h04, 32'h0, q, e);
    chk_val(q, 32'h3);
    rd(OP_REG_RD, 5'h01, 5'h01, d);
    apb(1'b0, 8'h20, 32'h0, q, e);
    chk_bit(e, 1'b1);
    // Reset in mid-frame must restore presets and leave the link usable
    apb(1'b1, 8'h00, {OP_REG_WR, 5'h00, 8'h11, 16'h0}, q, e);
    apb(1'b1, 8'h04, 32'h101, q, e);
    repeat (100) @(posedge pclk);
    presetn <= 1'b0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    {e_w0, e_w1, e_ctl} = {8'h40, 8'h40, 8'h40};
    @(posedge pclk);
    chk_regs();
    wr(OP_REG_WR, 5'h01, 8'h33);
    e_w1 = 8'h33;
    chk_regs();
    complete_run();
  end
endmodule
